// [hdl/sdrpd_pkg.sv]
// Constants and types for the command decode and power-state block
package sdrpd_pkg;

  // Command strobe encodings {row, column, write-enable}, active low
  localparam logic [2:0] SDRPD_ENC_MRS = 3'h0;
  localparam logic [2:0] SDRPD_ENC_REF = 3'h1;
  localparam logic [2:0] SDRPD_ENC_PRE = 3'h2;
  localparam logic [2:0] SDRPD_ENC_ACT = 3'h3;
  localparam logic [2:0] SDRPD_ENC_WR  = 3'h4;
  localparam logic [2:0] SDRPD_ENC_RD  = 3'h5;
  localparam logic [2:0] SDRPD_ENC_NOP = 3'h7;

  localparam int SDRPD_BANK_W      = 2;
  localparam int SDRPD_BANKS       = 4;
  localparam int SDRPD_ADDR_W      = 13;
  localparam int SDRPD_AP_BIT      = 10;
  localparam int SDRPD_EXIT_SEL_BIT = 12;
  localparam int SDRPD_BURST_LEN   = 4;
  localparam int SDRPD_BURST_W     = 3;
  localparam logic [SDRPD_BURST_W-1:0] SDRPD_BURST_CYC = 3'h2;  // Beats/2 clock cycles

  // Exit timings, in clock cycles at the device clock
  localparam int SDRPD_EXIT_W      = 4;
  localparam logic [SDRPD_EXIT_W-1:0] SDRPD_FAST_EXIT_CYC = 4'h2;
  localparam logic [SDRPD_EXIT_W-1:0] SDRPD_SLOW_EXIT_CYC = 4'h6;
  localparam logic [SDRPD_EXIT_W-1:0] SDRPD_PD_EXIT_CYC   = 4'h2;

  typedef enum logic [2:0] {
    SDRPD_CMD_NOP  = 3'h0,
    SDRPD_CMD_MRS  = 3'h1,
    SDRPD_CMD_REF  = 3'h2,
    SDRPD_CMD_PRE  = 3'h3,
    SDRPD_CMD_ACT  = 3'h4,
    SDRPD_CMD_WR   = 3'h5,
    SDRPD_CMD_RD   = 3'h6,
    SDRPD_CMD_ILL  = 3'h7
  } sdrpd_cmd_t;

  // Gray codes along idle -> active -> active powerdown
  typedef enum logic [2:0] {
    SDRPD_ST_IDLE   = 3'h0,
    SDRPD_ST_ACTIVE = 3'h1,
    SDRPD_ST_APD    = 3'h3,
    SDRPD_ST_PPD    = 3'h2,
    SDRPD_ST_SREF   = 3'h6
  } sdrpd_state_t;

endpackage

// [hdl/sdrpd_ctrl.sv]
// Command decoder and power-state controller for a 4-bank synchronous DRAM
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Active powerdown exit waits fast or slow interval chosen by stored address bit 12.
// - Chip select low with all three strobes high registers a no-operation.
// - A no-operation leaves running work, including bursts, untouched.
// - Chip select high is deselect, acting as no-operation; strobes ignored.
// - Commands decode only from select, strobes and clock enable at the rising edge.
// - Strobe codes give mode set, refresh, precharge, activate, write, read; bit ten all-bank.
// - Bank inputs choose the bank, or the mode register for mode writes.
// - Bursts of four always finish and are not cut short.
// - No termination in self-refresh; termination input never alters decoding or state.
// - Clock enable falling enters, rising exits powerdown, only with no-operation or deselect.
// - Self-refresh is entered only from all-idle on refresh with clock enable falling.
module sdrpd_ctrl
  import sdrpd_pkg::*;
#(
  parameter int BANKS  = SDRPD_BANKS,
  parameter int ADDR_W = SDRPD_ADDR_W
) (
  input  wire logic                    clock_i,
  input  wire logic                    nrst_i,
  input  wire logic                    cke_i,
  input  wire logic                    cs_n_i,
  input  wire logic                    ras_n_i,
  input  wire logic                    cas_n_i,
  input  wire logic                    we_n_i,
  input  wire logic [SDRPD_BANK_W-1:0] bank_i,
  input  wire logic [ADDR_W-1:0]       addr_i,
  input  wire logic                    die_termination_ctrl_i,
  output logic [2:0]                   cmd_o,
  output logic                         cmd_valid_o,
  output logic [SDRPD_BANK_W-1:0]      cmd_bank_o,
  output logic                         all_banks_o,
  output logic                         mode_wr_o,
  output logic [SDRPD_BANK_W-1:0]      mode_reg_sel_o,
  output logic [BANKS-1:0]             bank_open_o,
  output logic                         burst_busy_o,
  output logic                         powerdown_o,
  output logic                         active_pd_o,
  output logic                         self_refresh_o,
  output logic                         exit_pending_o,
  output logic                         exit_speed_select_bit_o,
  output logic                         termination_on_o,
  output logic                         illegal_o
);

  // ==========================================================
  // Command decode
  // ==========================================================
  logic         cke_prev_r;
  sdrpd_state_t state_r;
  sdrpd_cmd_t   cmd;
  logic         is_nop;

  always_comb begin
    is_nop = cs_n_i | ({ras_n_i, cas_n_i, we_n_i} == SDRPD_ENC_NOP);
    cmd = SDRPD_CMD_NOP;
    if (!is_nop) begin
      case ({ras_n_i, cas_n_i, we_n_i})
        SDRPD_ENC_MRS: cmd = SDRPD_CMD_MRS;
        SDRPD_ENC_REF: cmd = SDRPD_CMD_REF;
        SDRPD_ENC_PRE: cmd = SDRPD_CMD_PRE;
        SDRPD_ENC_ACT: cmd = SDRPD_CMD_ACT;
        SDRPD_ENC_WR:  cmd = SDRPD_CMD_WR;
        SDRPD_ENC_RD:  cmd = SDRPD_CMD_RD;
        default:       cmd = SDRPD_CMD_ILL;
      endcase
    end
  end

  wire logic in_pd     = (state_r == SDRPD_ST_APD) || (state_r == SDRPD_ST_PPD)
                         || (state_r == SDRPD_ST_SREF);
  wire logic normal    = cke_prev_r && cke_i && !in_pd;
  wire logic cke_fall  = cke_prev_r && !cke_i;
  wire logic cke_rise  = !cke_prev_r && cke_i;
  wire logic exit_busy = exit_pending_o;
  // Commands during an exit interval are not executable
  wire logic cmd_go    = normal && !exit_busy && !is_nop;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cke_prev_r <= 1'b0;
    end else begin
      cke_prev_r <= cke_i;
    end
  end

  // ==========================================================
  // Registered command outputs
  // ==========================================================
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd_o          <= SDRPD_CMD_NOP;
      cmd_valid_o    <= 1'b0;
      cmd_bank_o     <= '0;
      all_banks_o    <= 1'b0;
      mode_wr_o      <= 1'b0;
      mode_reg_sel_o <= '0;
    end else begin
      cmd_o          <= cmd_go ? cmd : SDRPD_CMD_NOP;
      cmd_valid_o    <= cmd_go;
      cmd_bank_o     <= bank_i;
      all_banks_o    <= cmd_go && addr_i[SDRPD_AP_BIT];
      mode_wr_o      <= cmd_go && (cmd == SDRPD_CMD_MRS);
      mode_reg_sel_o <= (cmd_go && cmd == SDRPD_CMD_MRS) ? bank_i : mode_reg_sel_o;
    end
  end

  // ==========================================================
  // Mode bit that picks the active powerdown exit speed
  // ==========================================================
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exit_speed_select_bit_o <= 1'b0;
    end else if (cmd_go && cmd == SDRPD_CMD_MRS && bank_i == '0) begin
      exit_speed_select_bit_o <= addr_i[SDRPD_EXIT_SEL_BIT];
    end
  end

  // ==========================================================
  // Bank open tracking
  // ==========================================================
  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          bank_open_o[g] <= 1'b0;
        end else if (cmd_go && cmd == SDRPD_CMD_ACT && bank_i == g) begin
          bank_open_o[g] <= 1'b1;
        end else if (cmd_go && cmd == SDRPD_CMD_PRE
                     && (addr_i[SDRPD_AP_BIT] || bank_i == g)) begin
          bank_open_o[g] <= 1'b0;
        end else if (cmd_go && (cmd == SDRPD_CMD_RD || cmd == SDRPD_CMD_WR)
                     && addr_i[SDRPD_AP_BIT] && bank_i == g) begin
          bank_open_o[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Burst tracking: a running burst is never cut short
  // ==========================================================
  logic [SDRPD_BURST_W-1:0] burst_cnt_r;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      burst_cnt_r  <= '0;
      burst_busy_o <= 1'b0;
    // A read or write in the last burst cycle chains a new burst, so it is tracked too
    end else if ((burst_cnt_r == '0 || burst_cnt_r == 3'h1) && cmd_go
                 && (cmd == SDRPD_CMD_RD || cmd == SDRPD_CMD_WR)) begin
      burst_cnt_r  <= SDRPD_BURST_CYC;
      burst_busy_o <= 1'b1;
    end else if (burst_cnt_r != '0) begin
      // Decrements on no-operation as on any other cycle
      burst_cnt_r  <= burst_cnt_r - 1'b1;
      burst_busy_o <= (burst_cnt_r != 3'h1);
    end
  end

  // ==========================================================
  // Power state machine
  // ==========================================================
  logic [SDRPD_EXIT_W-1:0] exit_cnt_r;
  wire logic any_open = |bank_open_o;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= SDRPD_ST_IDLE;
    end else begin
      case (state_r)
        SDRPD_ST_IDLE, SDRPD_ST_ACTIVE: begin
          if (cke_fall && is_nop && burst_cnt_r == '0) begin
            state_r <= any_open ? SDRPD_ST_APD : SDRPD_ST_PPD;
          end else if (cke_fall && !cs_n_i && cmd == SDRPD_CMD_REF && !any_open) begin
            state_r <= SDRPD_ST_SREF;
          end else begin
            state_r <= any_open ? SDRPD_ST_ACTIVE : SDRPD_ST_IDLE;
          end
        end
        SDRPD_ST_APD: begin
          if (cke_rise && is_nop) begin
            state_r <= SDRPD_ST_ACTIVE;
          end
        end
        SDRPD_ST_PPD, SDRPD_ST_SREF: begin
          if (cke_rise && is_nop) begin
            state_r <= SDRPD_ST_IDLE;
          end
        end
        default: state_r <= SDRPD_ST_IDLE;
      endcase
    end
  end

  // Exit latency count after clock enable returns high
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      exit_cnt_r     <= '0;
      exit_pending_o <= 1'b0;
    end else if (cke_rise && is_nop && state_r == SDRPD_ST_APD) begin
      exit_cnt_r     <= exit_speed_select_bit_o ? SDRPD_SLOW_EXIT_CYC
                                                : SDRPD_FAST_EXIT_CYC;
      exit_pending_o <= 1'b1;
    end else if (cke_rise && is_nop && state_r == SDRPD_ST_PPD) begin
      exit_cnt_r     <= SDRPD_PD_EXIT_CYC;
      exit_pending_o <= 1'b1;
    end else if (exit_cnt_r != '0) begin
      exit_cnt_r     <= exit_cnt_r - 1'b1;
      exit_pending_o <= (exit_cnt_r != 4'h1);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      powerdown_o      <= 1'b0;
      active_pd_o      <= 1'b0;
      self_refresh_o   <= 1'b0;
      termination_on_o <= 1'b0;
      illegal_o        <= 1'b0;
    end else begin
      powerdown_o      <= (state_r == SDRPD_ST_APD) || (state_r == SDRPD_ST_PPD);
      active_pd_o      <= (state_r == SDRPD_ST_APD);
      self_refresh_o   <= (state_r == SDRPD_ST_SREF);
      // Termination follows its pin but never in self-refresh
      termination_on_o <= die_termination_ctrl_i && (state_r != SDRPD_ST_SREF);
      // Flags a non-idle command other than refresh on a clock-enable fall at a clock-enable edge, or an undefined code in normal operation
      illegal_o        <= ((cke_fall || cke_rise) && !is_nop
                           && !(cke_fall && cmd == SDRPD_CMD_REF))
                          || (normal && cmd == SDRPD_CMD_ILL);
    end
  end

endmodule

`default_nettype wire

// [tb/sdrpd_ctrl_sva.sv]
// Concurrent checks on the ports of the command decode and power-state block
`timescale 1ns/1ps
`default_nettype none
// ==========
// Checker
module sdrpd_ctrl_sva
  import sdrpd_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       cs_n_i,
  input wire logic       ras_n_i,
  input wire logic       cas_n_i,
  input wire logic       we_n_i,
  input wire logic [1:0] bank_i,
  input wire logic [12:0] addr_i,
  input wire logic       die_termination_ctrl_i,
  input wire logic [2:0] cmd_o,
  input wire logic       cmd_valid_o,
  input wire logic [1:0] cmd_bank_o,
  input wire logic       all_banks_o,
  input wire logic       mode_wr_o,
  input wire logic [1:0] mode_reg_sel_o,
  input wire logic       burst_busy_o,
  input wire logic       powerdown_o,
  input wire logic       active_pd_o,
  input wire logic       self_refresh_o,
  input wire logic       exit_pending_o,
  input wire logic       exit_speed_select_bit_o,
  input wire logic       termination_on_o
);
  wire logic [2:0] strb = {ras_n_i, cas_n_i, we_n_i};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  function automatic sdrpd_cmd_t dec(input logic [2:0] e);
    case (e)
      SDRPD_ENC_MRS: return SDRPD_CMD_MRS;
      SDRPD_ENC_REF: return SDRPD_CMD_REF;
      SDRPD_ENC_PRE: return SDRPD_CMD_PRE;
      SDRPD_ENC_ACT: return SDRPD_CMD_ACT;
      SDRPD_ENC_WR:  return SDRPD_CMD_WR;
      SDRPD_ENC_RD:  return SDRPD_CMD_RD;
      default:       return SDRPD_CMD_ILL;
    endcase
  endfunction
  a_desel_ignored: assert property (cs_n_i |=> !cmd_valid_o)
    else $error("deselect produced a command");
  a_nop_quiet: assert property (!cs_n_i && strb == 3'h7 |=> !cmd_valid_o)
    else $error("no-operation produced a command");
  a_cmd_decode: assert property (cmd_valid_o |-> cmd_o == dec($past(strb)))
    else $error("command decoded wrongly");
  a_bank_copy: assert property (cmd_valid_o |-> cmd_bank_o == $past(bank_i))
    else $error("command bank wrong");
  a_all_banks: assert property (cmd_valid_o |-> all_banks_o == $past(addr_i[10]))
    else $error("all-bank flag wrong");
  // A burst ends after two cycles unless a read or write taken in its last cycle chains on
  a_burst_two: assert property ($rose(burst_busy_o) |-> burst_busy_o[*2] ##1 (!burst_busy_o
    || (cmd_valid_o && (cmd_o == SDRPD_CMD_RD || cmd_o == SDRPD_CMD_WR))))
    else $error("burst length wrong");
  a_mode_write: assert property (mode_wr_o |-> cmd_valid_o && cmd_o == SDRPD_CMD_MRS
    && mode_reg_sel_o == cmd_bank_o)
    else $error("mode register select wrong");
  a_term_follow: assert property (termination_on_o
    == ($past(die_termination_ctrl_i) && !self_refresh_o))
    else $error("termination output wrong");
  a_pd_refuse: assert property (powerdown_o || self_refresh_o |-> !cmd_valid_o)
    else $error("command taken in power-down");
  a_exit_fast: assert property ($rose(exit_pending_o)
    && !(exit_speed_select_bit_o && $past(active_pd_o))
    |-> exit_pending_o[*2] ##1 !exit_pending_o)
    else $error("fast exit length wrong");
  a_exit_slow: assert property ($rose(exit_pending_o) && exit_speed_select_bit_o
    && $past(active_pd_o) |-> exit_pending_o[*6] ##1 !exit_pending_o)
    else $error("slow exit length wrong");
  a_sref_no_term: assert property (self_refresh_o && $past(self_refresh_o)
    |-> !termination_on_o)
    else $error("termination on in self-refresh");
  c_apd: cover property ($rose(active_pd_o));
  c_sref: cover property ($rose(self_refresh_o));
  c_burst: cover property ($rose(burst_busy_o));
endmodule
`default_nettype wire

// [tb/sdrpd_mc_model.sv]
// Memory controller model driving command pins and clock enable
`timescale 1ns/1ps
`default_nettype none
// ==========
// Controller
module sdrpd_mc_model (
  input  wire logic        clock_i,
  output logic             cke_o,
  output logic             cs_n_o,
  output logic [2:0]       cmd_n_o,
  output logic [1:0]       bank_o,
  output logic [12:0]      addr_o
);
  initial begin
    cke_o = 1'b0;
    cs_n_o = 1'b1;
    cmd_n_o = 3'h7;
    bank_o = 2'h0;
    addr_o = 13'h0000;
  end
  // Callers keep NO_OPERATION_CMD on every clock-enable edge except self-refresh entry on refresh, and short power-down spans
  task automatic put(input logic k, input logic c, input logic [2:0] e,
                     input logic [1:0] b, input logic [12:0] a);
    @(posedge clock_i);
    #5;
    cke_o = k;
    cs_n_o = c;
    cmd_n_o = e;
    bank_o = b;
    addr_o = a;
  endtask
endmodule
`default_nettype wire

// [tb/sdrpd_ctrl_test.sv]
// Self-checking testbench for the command decode and power-state block
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module sdrpd_ctrl_test
  import sdrpd_pkg::*;
;
  logic clock_i, nrst_i, term, cke, cs_n, vld, allb, busy, pd, apd, sr, exitp, xbit, ton;
  logic [2:0] strb, cmd;
  logic [1:0] bank, cbank;
  logic [12:0] addr;
  logic [3:0] bopen;
  logic mwr, ill;
  logic [1:0] msel;
  int n_mismatch, total_checks, nb, ne;
  logic [2:0] encs [6] = '{SDRPD_ENC_MRS, SDRPD_ENC_REF, SDRPD_ENC_PRE,
                           SDRPD_ENC_ACT, SDRPD_ENC_WR, SDRPD_ENC_RD};
  sdrpd_cmd_t exps [6] = '{SDRPD_CMD_MRS, SDRPD_CMD_REF, SDRPD_CMD_PRE,
                           SDRPD_CMD_ACT, SDRPD_CMD_WR, SDRPD_CMD_RD};
  sdrpd_ctrl u_dut (
    .clock_i(clock_i), .nrst_i(nrst_i), .cke_i(cke), .cs_n_i(cs_n),
    .ras_n_i(strb[2]), .cas_n_i(strb[1]), .we_n_i(strb[0]), .bank_i(bank),
    .addr_i(addr), .die_termination_ctrl_i(term), .cmd_o(cmd), .cmd_valid_o(vld),
    .cmd_bank_o(cbank), .all_banks_o(allb), .mode_wr_o(mwr), .mode_reg_sel_o(msel),
    .bank_open_o(bopen), .burst_busy_o(busy), .powerdown_o(pd), .active_pd_o(apd),
    .self_refresh_o(sr), .exit_pending_o(exitp), .exit_speed_select_bit_o(xbit),
    .termination_on_o(ton), .illegal_o(ill));
  sdrpd_mc_model u_mc (.clock_i(clock_i), .cke_o(cke), .cs_n_o(cs_n),
    .cmd_n_o(strb), .bank_o(bank), .addr_o(addr));
  initial begin
    clock_i = 1'b0;
    // One fixed rate that never stops, so no frequency change or relock is ever needed
    forever #50 clock_i = ~clock_i;
  end
  // Sampled on the edge itself, so the values seen are the settled ones
  always @(posedge clock_i) begin
    nb += (busy === 1'b1);
    ne += (exitp === 1'b1);
  end
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #5;
  endtask
  task cmd_chk(input logic [2:0] e, input logic [1:0] b, input logic [12:0] a,
               input sdrpd_cmd_t x);
    u_mc.put(1'b1, 1'b0, e, b, a);
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    chk(vld === 1'b1 && cmd === x && cbank === b && allb === a[10], "decode");
    chk(mwr === (x == SDRPD_CMD_MRS), "mode write");
  endtask
  // Entry, a refused command inside, then exit with a counted latency
  task pd_cycle(input logic exp_apd, input int exp_n);
    ne = 0;
    u_mc.put(1'b0, 1'b1, 3'h7, 2'h0, 13'h0000);
    cyc(3);
    chk(pd === 1'b1 && apd === exp_apd, "power-down entry");
    u_mc.put(1'b0, 1'b0, SDRPD_ENC_ACT, 2'h2, 13'h0000);
    u_mc.put(1'b0, 1'b1, 3'h7, 2'h0, 13'h0000);
    chk(vld !== 1'b1 && bopen[2] !== 1'b1, "taken in power-down");
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    cyc(10);
    chk(ne == exp_n && pd === 1'b0, "exit latency");
  endtask
  task wrap_up;
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200_000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    nrst_i = 1'b0;
    term = 1'b0;
    repeat (20) @(posedge clock_i);
    #5;
    nrst_i = 1'b1;
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    for (int i = 0; i < 6; i++) begin
      cmd_chk(encs[i], (i > 2) ? 2'h1 : 2'h0, (i == 2) ? 13'h0400 : 13'h0000, exps[i]);
    end
    // Extended mode write on bank 1 must leave the exit-speed bit alone
    cmd_chk(SDRPD_ENC_MRS, 2'h1, 13'h1000, SDRPD_CMD_MRS);
    chk(bopen[1] === 1'b1 && xbit === 1'b0 && msel === 2'h1, "bank open");
    cmd_chk(SDRPD_ENC_ACT, 2'h3, 13'h0000, SDRPD_CMD_ACT);
    cmd_chk(SDRPD_ENC_RD, 2'h3, 13'h0400, SDRPD_CMD_RD);
    chk(bopen[3] !== 1'b1 && bopen[1] === 1'b1, "auto-precharge");
    u_mc.put(1'b1, 1'b1, SDRPD_ENC_ACT, 2'h2, 13'h0000);
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    chk(vld !== 1'b1 && bopen[2] !== 1'b1, "deselect");
    u_mc.put(1'b1, 1'b0, 3'h6, 2'h2, 13'h0000);
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    chk(ill === 1'b1 && cmd === SDRPD_CMD_ILL, "undefined code");
    nb = 0;
    u_mc.put(1'b1, 1'b0, SDRPD_ENC_RD, 2'h1, 13'h0000);
    u_mc.put(1'b1, 1'b0, SDRPD_ENC_RD, 2'h1, 13'h0000);
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    cyc(4);
    chk(nb == SDRPD_BURST_CYC, "burst length");
    // A read in the last cycle of a burst chains a second full burst
    nb = 0;
    u_mc.put(1'b1, 1'b0, SDRPD_ENC_RD, 2'h1, 13'h0000);
    u_mc.put(1'b1, 1'b0, 3'h7, 2'h0, 13'h0000);
    u_mc.put(1'b1, 1'b0, SDRPD_ENC_RD, 2'h1, 13'h0000);
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    cyc(4);
    chk(nb == 2 * SDRPD_BURST_CYC, "chained burst");
    pd_cycle(1'b1, SDRPD_FAST_EXIT_CYC);
    cmd_chk(SDRPD_ENC_MRS, 2'h0, 13'h1000, SDRPD_CMD_MRS);
    chk(xbit === 1'b1 && msel === 2'h0, "exit speed bit");
    pd_cycle(1'b1, SDRPD_SLOW_EXIT_CYC);
    cmd_chk(SDRPD_ENC_PRE, 2'h0, 13'h0400, SDRPD_CMD_PRE);
    pd_cycle(1'b0, SDRPD_PD_EXIT_CYC);
    term = 1'b1;
    cyc(2);
    chk(ton === 1'b1, "termination idle");
    u_mc.put(1'b0, 1'b0, SDRPD_ENC_REF, 2'h0, 13'h0000);
    u_mc.put(1'b0, 1'b1, 3'h7, 2'h0, 13'h0000);
    cyc(3);
    chk(sr === 1'b1 && ton === 1'b0, "self-refresh entry");
    u_mc.put(1'b1, 1'b1, 3'h7, 2'h0, 13'h0000);
    cyc(10);
    chk(sr === 1'b0, "self-refresh exit");
    wrap_up;
  end
endmodule
bind sdrpd_ctrl sdrpd_ctrl_sva u_sva (
  .clock_i(clock_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i), .ras_n_i(ras_n_i),
  .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_i(bank_i), .addr_i(addr_i),
  .die_termination_ctrl_i(die_termination_ctrl_i), .cmd_o(cmd_o),
  .cmd_valid_o(cmd_valid_o), .cmd_bank_o(cmd_bank_o), .all_banks_o(all_banks_o),
  .mode_wr_o(mode_wr_o), .mode_reg_sel_o(mode_reg_sel_o), .burst_busy_o(burst_busy_o),
  .powerdown_o(powerdown_o), .active_pd_o(active_pd_o), .self_refresh_o(self_refresh_o),
  .exit_pending_o(exit_pending_o), .exit_speed_select_bit_o(exit_speed_select_bit_o),
  .termination_on_o(termination_on_o));
`default_nettype wire
